// ===== verilog/twefe_pkg.sv
// Package of constants, states and carriers for the two-wire EEPROM front end
package twefe_pkg;
  // ----------------------------------------------------------------
  // Device address word
  // ----------------------------------------------------------------
  localparam logic [3:0] TWEFE_TYPE_ID = 4'hA;
  localparam int TWEFE_ID_MSB = 7;
  localparam int TWEFE_ID_LSB = 4;
  localparam int TWEFE_SEL_MSB_POS = 3;
  localparam int TWEFE_SEL_MID_POS = 2;
  localparam int TWEFE_SEL_LSB_POS = 1;
  localparam int TWEFE_RW_POS = 0;
  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int TWEFE_PAGES = 32;
  localparam int TWEFE_PAGE_2K = 8;
  localparam int TWEFE_PAGE_4K = 16;
  localparam int TWEFE_AW_2K = 8;
  localparam int TWEFE_AW_4K = 9;
  localparam int TWEFE_AW_MAX = 9;
  localparam logic [3:0] TWEFE_BIT_LAST = 4'h7;
  localparam logic [3:0] TWEFE_BIT_ACK = 4'h8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TWEFE_CLK_HZ = 25000000;
  localparam int TWEFE_PROG_TIME_MS = 5;
  localparam int TWEFE_PROG_CYCLES = TWEFE_CLK_HZ / 1000 * TWEFE_PROG_TIME_MS;
  // ----------------------------------------------------------------
  // States and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TWEFE_IDLE = 3'h0,
    TWEFE_DEV = 3'h1,
    TWEFE_WADR = 3'h3,
    TWEFE_WDAT = 3'h2,
    TWEFE_RDAT = 3'h6,
    TWEFE_PROG = 3'h7
  } twefe_state_t;

  typedef struct packed {
    logic [7:0] data;
    logic [8:0] addr;
  } twefe_wr_t;
endpackage : twefe_pkg

// ===== verilog/twefe_fifo.sv
// Write buffer FIFO with registered read data
`timescale 1ns/1ps
module twefe_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
    logic ov;
    logic [WIDTH-1:0] od;
  } twefe_fst_t;
  twefe_fst_t st_reg;
  twefe_fst_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] count;
  logic pop;
  logic push;
  assign count = st_reg.wp - st_reg.rp;
  assign in_ready = count != DEPTH[PW:0];
  assign push = in_valid && in_ready;
  assign pop = (!st_reg.ov || out_ready) && count != '0;
  assign out_valid = st_reg.ov;
  assign out_data = st_reg.od;
  always_comb
  begin
    st_next = st_reg;
    if (out_ready)
    begin
      st_next.ov = 1'b0;
    end
    if (pop)
    begin
      st_next.ov = 1'b1;
      st_next.od = mem[st_reg.rp[PW-1:0]];
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push)
    begin
      st_next.wp = st_reg.wp + 1'b1;
    end
  end
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[st_reg.wp[PW-1:0]] <= in_data;
    end
    if (!nrst)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule : twefe_fifo

// ===== verilog/twefe_frontend.sv
// Two-wire serial EEPROM bus front end, target side
//
// Operation
// [RL1] Sample on clock rise, drive on fall
// [RL2] Data line is open drain only
// [RL3] Guard high blocks all array writes
// [RL4] Small variant: 32x8 pages, 8-bit address
// [RL5] Large variant: 32x16 pages, 9-bit address
// [RL6] Data changes only while clock low
// [RL7] Data fall, clock high: start
// [RL8] Data rise, clock high: stop
// [RL9] Acknowledge each word in ninth clock
// [RL10] Standby at power-up and after stop
// [RL11] Host recovers bus with nine clocks
// [RL12] Device address word follows every start
// [RL13] Upper four bits must match type
// [RL14] Small variant compares three select pins
// [RL15] Large variant: lowest select is page bit
// [RL16] Lowest bit selects read or write
// [RL17] Ack on match, else standby
// [RL18] Internal program finishes within 5 ms
// [RL19] No ack during program cycle
// [RL20] Page writes wrap within the page
// [RL21] Counter holds last address plus one
// [RL22] Sequential read continues while host acks
// [RL23] Type identifier is binary 1010
// [RL24] Protected writes acked but discarded
`timescale 1ns/1ps
module twefe_frontend
  import twefe_pkg::*;
#(
  parameter bit LARGE = 1'b0,
  parameter int PROG_CYCLES = TWEFE_PROG_CYCLES,
  parameter int BUF_DEPTH = TWEFE_PAGE_4K * 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Two-wire bus pins
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Hard-wired pins
  input wire logic select_pin_lsb,
  input wire logic select_pin_mid,
  input wire logic select_pin_msb,
  input wire logic write_guard,
  // Array port
  output logic mem_we,
  output logic [8:0] mem_waddr,
  output logic [7:0] mem_wdata,
  output logic [8:0] mem_raddr,
  input wire logic [7:0] mem_rdata,
  // Status
  output logic standby,
  output logic busy
);
  localparam int AW = LARGE ? TWEFE_AW_4K : TWEFE_AW_2K;
  localparam int PB = $clog2(LARGE ? TWEFE_PAGE_4K : TWEFE_PAGE_2K);
  localparam logic [8:0] AMASK = 9'((1 << AW) - 1);
  localparam logic [8:0] PMASK = 9'((LARGE ? TWEFE_PAGE_4K : TWEFE_PAGE_2K) - 1);
  localparam logic [22:0] PCNT = 23'(PROG_CYCLES);

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    twefe_state_t fsm;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [8:0] addr;
    logic rd_ok;
    logic drive_low;
    logic ack_ph;
    logic wr_any;
    logic [22:0] pcnt;
    logic [7:0] txd;
  } twefe_st_t;
  twefe_st_t st_reg;
  twefe_st_t st_next;

  logic scl_q;
  logic sda_q;
  logic scl_p;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic id_ok;
  logic sel_ok;
  logic f_ready;
  logic f_valid;
  logic f_push;
  twefe_wr_t f_in;
  twefe_wr_t f_out;

  // ----------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ----------------------------------------------------------------
  // Bus pins are asynchronous to clock: s1 feeds s2 only
  assign scl_q = st_reg.s2[1];
  assign sda_q = st_reg.s2[0];
  assign scl_p = st_reg.s3[1];
  assign sda_p = st_reg.s3[0];
  assign scl_rise = scl_q && !scl_p; // [RL1]
  assign scl_fall = !scl_q && scl_p; // [RL1]
  assign start_c = scl_q && scl_p && sda_p && !sda_q; // [RL7] [RL6]
  assign stop_c = scl_q && scl_p && !sda_p && sda_q; // [RL8] [RL6]

  // ----------------------------------------------------------------
  // Address word compare
  // ----------------------------------------------------------------
  // Compared at the fall after the eighth rise, when the whole word sits in sh
  assign id_ok = st_reg.sh[TWEFE_ID_MSB:TWEFE_ID_LSB] == TWEFE_TYPE_ID; // [RL13] [RL23]
  always_comb
  begin
    sel_ok = st_reg.sh[TWEFE_SEL_MSB_POS] == select_pin_msb &&
             st_reg.sh[TWEFE_SEL_MID_POS] == select_pin_mid; // [RL14] [RL15]
    if (!LARGE)
    begin
      sel_ok = sel_ok && st_reg.sh[TWEFE_SEL_LSB_POS] == select_pin_lsb; // [RL14]
    end
  end

  // ----------------------------------------------------------------
  // Bus state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] word;
    logic [8:0] nxt;
    word = {st_reg.sh[6:0], sda_q};
    nxt = '0;
    st_next = st_reg;
    f_push = 1'b0;
    f_in.data = st_reg.sh;
    f_in.addr = st_reg.addr;
    st_next.s1 = {scl, sda_in};
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.fsm == TWEFE_PROG)
    begin
      // Pins ignored while programming; writes drain from the buffer
      if (st_reg.pcnt != '0)
      begin
        st_next.pcnt = st_reg.pcnt - 1'b1; // [RL18]
      end
      else if (!f_valid)
      begin
        st_next.fsm = TWEFE_IDLE; // [RL19] [RL10]
      end
      st_next.drive_low = 1'b0;
    end
    else if (start_c)
    begin
      st_next.fsm = TWEFE_DEV; // [RL7] [RL12]
      st_next.bitn = '0;
      st_next.ack_ph = 1'b0;
      st_next.drive_low = 1'b0;
    end
    else if (stop_c)
    begin
      st_next.drive_low = 1'b0;
      st_next.ack_ph = 1'b0;
      if (st_reg.wr_any)
      begin
        st_next.fsm = TWEFE_PROG; // [RL19]
        st_next.pcnt = PCNT;
        st_next.wr_any = 1'b0;
      end
      else
      begin
        st_next.fsm = TWEFE_IDLE; // [RL8] [RL10]
      end
    end
    else if (st_reg.fsm != TWEFE_IDLE)
    begin
      if (scl_rise && !st_reg.ack_ph)
      begin
        st_next.sh = word; // [RL1]
        st_next.bitn = st_reg.bitn + 1'b1;
      end
      else if (scl_rise && st_reg.ack_ph && st_reg.fsm == TWEFE_RDAT)
      begin
        // Host ack in the ninth clock keeps the read going
        st_next.rd_ok = !sda_q; // [RL22]
      end
      if (scl_fall && !st_reg.ack_ph && st_reg.bitn == TWEFE_BIT_ACK)
      begin
        st_next.ack_ph = 1'b1;
        st_next.bitn = '0;
        case (st_reg.fsm)
          TWEFE_DEV:
          begin
            if (id_ok && sel_ok) // [RL17]
            begin
              st_next.drive_low = 1'b1; // [RL9]
              if (LARGE)
              begin
                st_next.addr[8] = st_reg.sh[TWEFE_SEL_LSB_POS]; // [RL15]
              end
              if (st_reg.sh[TWEFE_RW_POS]) // [RL16]
              begin
                st_next.fsm = TWEFE_RDAT;
                st_next.rd_ok = 1'b1;
              end
              else
              begin
                st_next.fsm = TWEFE_WADR;
              end
            end
            else
            begin
              st_next.fsm = TWEFE_IDLE; // [RL17]
              st_next.ack_ph = 1'b0;
            end
          end
          TWEFE_WADR:
          begin
            st_next.drive_low = 1'b1; // [RL9]
            st_next.addr[7:0] = st_reg.sh; // [RL4] [RL5]
            st_next.fsm = TWEFE_WDAT;
          end
          TWEFE_WDAT:
          begin
            st_next.drive_low = 1'b1; // [RL9] [RL24]
            f_push = !write_guard && f_ready; // [RL3] [RL24]
            st_next.wr_any = st_reg.wr_any || f_push;
            nxt = (st_reg.addr & ~PMASK) | ((st_reg.addr + 1'b1) & PMASK);
            st_next.addr = nxt; // [RL20] [RL21]
          end
          TWEFE_RDAT:
          begin
            st_next.drive_low = 1'b0;
          end
          default:
          begin
            st_next.fsm = TWEFE_IDLE;
          end
        endcase
      end
      else if (scl_fall && st_reg.ack_ph)
      begin
        st_next.ack_ph = 1'b0;
        st_next.drive_low = 1'b0;
        if (st_reg.fsm == TWEFE_RDAT)
        begin
          if (st_reg.rd_ok)
          begin
            st_next.txd = mem_rdata;
            st_next.addr = (st_reg.addr + 1'b1) & AMASK; // [RL21]
            st_next.drive_low = !mem_rdata[7]; // [RL1]
          end
          else
          begin
            st_next.fsm = TWEFE_IDLE; // [RL22]
          end
        end
      end
      else if (scl_fall && st_reg.fsm == TWEFE_RDAT && st_reg.bitn != '0)
      begin
        // Next bit shifts out on the falling edge
        st_next.drive_low = st_reg.bitn == TWEFE_BIT_ACK ? 1'b0 :
                            !st_reg.txd[TWEFE_BIT_LAST[2:0] - st_reg.bitn[2:0]]; // [RL1]
      end
    end
    if (!nrst)
    begin
      st_next = '0; // [RL10]
    end
  end

  always_ff @(posedge clock)
  begin
    st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Write buffer and array port
  // ----------------------------------------------------------------
  // Buffer takes a whole page so the program cycle commits it at once
  twefe_fifo #(.WIDTH($bits(twefe_wr_t)), .DEPTH(BUF_DEPTH)) u_fifo (
    .clock(clock),
    .nrst(nrst),
    .in_valid(f_push),
    .in_ready(f_ready),
    .in_data(f_in),
    .out_valid(f_valid),
    .out_ready(st_reg.fsm == TWEFE_PROG),
    .out_data(f_out)
  );

  assign mem_we = f_valid && st_reg.fsm == TWEFE_PROG && !write_guard; // [RL3]
  assign mem_waddr = f_out.addr & AMASK;
  assign mem_wdata = f_out.data;
  assign mem_raddr = st_reg.addr & AMASK;
  assign sda_out = 1'b0; // [RL2]
  assign sda_oe = st_reg.drive_low; // [RL2]
  assign standby = st_reg.fsm == TWEFE_IDLE;
  assign busy = st_reg.fsm == TWEFE_PROG;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence dev_word_done;
    st_reg.fsm == TWEFE_DEV && scl_fall && st_reg.bitn == TWEFE_BIT_ACK;
  endsequence
  chk_pin_open_drain: assert property (@(posedge clock) disable iff (!nrst) // [RL2]
    sda_out == 1'b0) else $error("data pin driven high");
  chk_start_detect: assert property (@(posedge clock) disable iff (!nrst) // [RL7]
    start_c && st_reg.fsm != TWEFE_PROG |=> st_reg.fsm == TWEFE_DEV)
    else $error("start missed");
  chk_stop_idle: assert property (@(posedge clock) disable iff (!nrst) // [RL10]
    stop_c && !st_reg.wr_any && st_reg.fsm != TWEFE_PROG |=> standby)
    else $error("no standby after stop");
  chk_match_ack: assert property (@(posedge clock) disable iff (!nrst) // [RL17]
    dev_word_done and (id_ok && sel_ok && !start_c && !stop_c) |=> sda_oe)
    else $error("address not acknowledged");
  chk_mismatch_nak: assert property (@(posedge clock) disable iff (!nrst) // [RL13]
    dev_word_done and (!id_ok && !start_c && !stop_c) |=> !sda_oe && standby)
    else $error("wrong type acknowledged");
  chk_select_nak: assert property (@(posedge clock) disable iff (!nrst) // [RL14]
    dev_word_done and (id_ok && !sel_ok && !start_c && !stop_c) |=> !sda_oe && standby)
    else $error("wrong select acknowledged");
  chk_prog_quiet: assert property (@(posedge clock) disable iff (!nrst) // [RL19]
    busy |-> !sda_oe) else $error("drove bus while programming");
  chk_guard_write: assert property (@(posedge clock) disable iff (!nrst) // [RL3]
    write_guard |-> !mem_we && !f_push) else $error("write under guard");
  chk_prog_start: assert property (@(posedge clock) disable iff (!nrst) // [RL18]
    stop_c && st_reg.wr_any && !busy |=> busy && st_reg.pcnt == PCNT)
    else $error("program cycle not started");
  chk_page_wrap: assert property (@(posedge clock) disable iff (!nrst) // [RL20]
    f_push |=> st_reg.addr[8:PB] == $past(st_reg.addr[8:PB]))
    else $error("page row changed");
endmodule : twefe_frontend

// ===== verification/twefe_host.sv
// Bus host model that drives the two-wire pins of the front end
`timescale 1ns/1ps
module twefe_host (
  // Wire level as seen on the bus
  input wire logic sda,
  // Host side of the bus
  output logic scl,
  output logic sda_low
);
  // ------------------------------------------------------------
  // Idle bus: clock stands high, data released to the pull-up
  // ------------------------------------------------------------
  initial
  begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // Data falls while clock is high
  task automatic start();
    sda_low = 1'h0;
    #80;
    scl = 1'h1;
    #160;
    sda_low = 1'h1;
    #160;
    scl = 1'h0;
    #80;
  endtask : start

  // Data rises while clock is high
  task automatic stop();
    sda_low = 1'h1;
    #80;
    scl = 1'h1;
    #160;
    sda_low = 1'h0;
    #160;
  endtask : stop

  // Data changes only in the low phase; sampled late in the high phase
  // because the device answers a few system clocks after each fall
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #80;
    scl = 1'h1;
    #150;
    r = sda;
    #10;
    scl = 1'h0;
    #80;
  endtask : bit_io

  // Eight bits MSB first, then the ninth clock for the acknowledge
  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ninth);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, ninth);
  endtask : byte_io

  // Nine released clocks to free a stuck bus; data must read high each time
  task automatic recover(output logic all_high);
    logic r;
    all_high = 1'h1;
    repeat (9)
    begin
      bit_io(1'h1, r);
      all_high = all_high & r;
    end
  endtask : recover
endmodule : twefe_host

// ===== verification/test_twefe_frontend.sv
// Self-checking bench of the two-wire EEPROM front end, large variant
`timescale 1ns/1ps
module test_twefe_frontend;
  import twefe_pkg::*;
  // Long enough that an acknowledge poll fits inside the program cycle
  localparam int PROG = 200;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic [2:0] sel = 3'h0;
  logic write_guard = 1'h0;
  logic scl, h_low, sda, sda_out, sda_oe, mem_we, standby, busy, nine;
  logic [8:0] mem_waddr, mem_raddr, cnt;
  logic [7:0] mem_wdata, mem_rdata, rx;
  logic [7:0] mem [512];
  logic [7:0] exp_mem [512];
  logic [7:0] bad [4] = '{8'h80, 8'h10, 8'h08, 8'h04};
  logic [16:0] lfsr = 17'h16197;
  int n_mismatch = 0;
  int cmp_count = 0;

  twefe_frontend #(.LARGE(1'h1), .PROG_CYCLES(PROG)) DUT (
    .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .select_pin_lsb(sel[0]), .select_pin_mid(sel[1]),
    .select_pin_msb(sel[2]), .write_guard(write_guard), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_raddr(mem_raddr),
    .mem_rdata(mem_rdata), .standby(standby), .busy(busy));
  twefe_host host (.sda(sda), .scl(scl), .sda_low(h_low));

  // ------------------------------------------------------------
  // Clock, wired-AND data line and array model
  // ------------------------------------------------------------
  always #20 clock = ~clock;
  assign sda = ~(h_low | (sda_oe & ~sda_out));
  assign mem_rdata = mem[mem_raddr];
  always @(posedge clock)
    if (mem_we)
      mem[mem_waddr] <= mem_wdata;

  // ------------------------------------------------------------
  // Expectation helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return lfsr[7:0];
  endfunction : rnd

  // Low bit of the select field carries the page bit
  function automatic logic [7:0] dev(input logic rd, input logic page);
    return {TWEFE_TYPE_ID, sel[2], sel[1], page, rd};
  endfunction : dev

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000; i++)
    begin
      @(posedge clock);
      #1;
      if (busy === 1'h0 && standby === 1'h1)
        break;
    end
    if (i == 2000)
    begin
      n_mismatch++;
      end_of_test();
    end
  endtask : wait_idle

  // Write n bytes from a start address; counter follows the page wrap
  task automatic wr(input logic page, input logic [7:0] ad, input int n);
    logic [7:0] d;
    host.start();
    host.byte_io(dev(1'h0, page), 1'h1, rx, nine);
    check(nine, 1'h0);
    host.byte_io(ad, 1'h1, rx, nine);
    check(nine, 1'h0);
    cnt = {page, ad};
    for (int k = 0; k < n; k++)
    begin
      d = rnd();
      host.byte_io(d, 1'h1, rx, nine);
      check(nine, 1'h0);
      if (!write_guard)
        exp_mem[cnt] = d;
      cnt = {cnt[8:4], cnt[3:0] + 4'h1};
    end
    host.stop();
  endtask : wr

  // Read n bytes from the counter, acknowledging all but the last
  task automatic rd(input int n);
    host.start();
    host.byte_io(dev(1'h1, cnt[8]), 1'h1, rx, nine);
    check(nine, 1'h0);
    for (int k = 0; k < n; k++)
    begin
      host.byte_io(8'hFF, k == n - 1, rx, nine);
      check(rx, exp_mem[cnt]);
      cnt = cnt + 9'h1;
    end
    host.stop();
    wait_idle();
  endtask : rd

  task automatic cmp_array();
    for (int i = 0; i < 512; i++)
      check(mem[i], exp_mem[i]);
  endtask : cmp_array

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 512; i++)
    begin
      mem[i] = rnd();
      exp_mem[i] = mem[i];
    end
    sel = lfsr[2:0];
    repeat (2) @(posedge clock);
    #1;
    nrst = 1'h1;
    repeat (4) @(posedge clock);
    #1;
    check(standby, 1'h1);
    check({busy, sda_oe, sda_out}, 3'h0);
    host.recover(nine);
    check(nine, 1'h1);
    // Wrong type or wrong select: no acknowledge, back to standby
    foreach (bad[i])
    begin
      host.start();
      host.byte_io(dev(1'h0, 1'h0) ^ bad[i], 1'h1, rx, nine);
      check(nine, 1'h1);
      host.stop();
      wait_idle();
    end
    // Page writes that may run past the page end, with polling
    repeat (2)
    begin
      wr(lfsr[0], rnd(), 5 + (rnd() % 16));
      check(busy, 1'h1);
      host.start();
      host.byte_io(dev(1'h0, 1'h0), 1'h1, rx, nine);
      check(nine, 1'h1);
      host.stop();
      wait_idle();
      check(standby, 1'h1);
      cmp_array();
      rd(3);
    end
    // Random read across the end of the array
    wr(1'h1, 8'hFF, 0);
    check(busy, 1'h0);
    wait_idle();
    rd(2);
    // Guarded writes are acknowledged but change nothing
    write_guard = 1'h1;
    wr(lfsr[1], rnd(), 3);
    check(busy, 1'h0);
    wait_idle();
    cmp_array();
    end_of_test();
  end
endmodule : test_twefe_frontend
